// *** tmc_core.v ***
// Timer mode, control and status block with 16-bit counter and four channels.
// Assumes a simple strobe register port and pins synchronous to clk_in.
//
// Implementation choice: strobed register access.
`include "tmc_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tmc_core #(
  parameter CNT_W = 16
) (
  input wire clk_in,
  input wire reset_in,
  input wire [9:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [3:0] capture_sel_in,
  input wire [3:0] pin_in,
  input wire external_count_clock_in,
  input wire fast_onchip_osc_clock_in,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe_out,
  output wire [CNT_W-1:0] main_counter_out,
  output wire [3:0] pulse_mode_out,
  output wire triggered_wave_out,
  output wire [1:0] pairing_out,
  output wire running_out
);
  reg [7:0] mode_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] edge_reg;
  reg [4:0] flag_reg;
  reg [4:0] flag_next;
  reg [4:0] seen_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg [3:0] pin_d_reg;
  reg [3:0] lvl_reg;
  reg rd_gen_reg;
  reg rd_lo_reg;
  reg [7:0] rd_mux_reg;
  wire tick;
  wire [4*CNT_W-1:0] gen_all;
  wire [CNT_W-1:0] gen_rd;
  wire gen_wr;
  wire [1:0] gen_idx;
  wire [3:0] cap_hit;
  wire [3:0] cmp_hit;
  wire [3:0] evt;
  wire ovf_evt;
  wire wave_mode;
  wire capture_a;
  wire clear_a;
  wire pair_c;
  wire pair_d;
  wire [3:0] eff_pwm;
  integer j;
  integer k;
  // Low byte of a general register staged until the high byte write
  reg [7:0] lo_hold_reg [0:3];
  // General registers fill one aligned block of eight bytes
  localparam [9:0] GEN_BASE = `TMC_ADR_GEN_BASE;

  ////////////////////////////////////////////////////////////////
  // Helpers
  function [CNT_W-1:0] gen_word;
    input [4*CNT_W-1:0] all;
    input integer idx;
    begin
      gen_word = all[idx*CNT_W +: CNT_W];
    end
  endfunction

  // Staged low byte for one general register
  function [7:0] lvl_hold;
    input [1:0] idx;
    begin
      lvl_hold = lo_hold_reg[idx];
    end
  endfunction

  // Edge match for one channel; two-bit field picks rising, falling or both
  function edge_hit;
    input [1:0] sel;
    input now;
    input was;
    begin
      case (sel)
        `TMC_EDGE_RISE: edge_hit = now & ~was;
        `TMC_EDGE_FALL: edge_hit = ~now & was;
        default: edge_hit = now ^ was;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Mode decode
  assign wave_mode = ~mode_reg[`TMC_BIT_WAVE];
  // Pin select bits only count outside triggered waveform mode
  assign eff_pwm = {mode_reg[`TMC_BIT_PIN_D_PULSE_SELECT], mode_reg[`TMC_BIT_PIN_C_PULSE_SELECT],
                    mode_reg[`TMC_BIT_PIN_B_PULSE_SELECT], 1'b0} & {4{~wave_mode}};
  assign pair_c = mode_reg[`TMC_BIT_BFC];
  assign pair_d = mode_reg[`TMC_BIT_BFD];
  // Capture applies only in plain timer mode on a non-PWM channel
  assign capture_a = capture_sel_in[0] & ~wave_mode;
  // Clear select ignored while channel A captures
  assign clear_a = ctrl_reg[`TMC_BIT_COUNTER_CLEAR_SELECT] & ~capture_a;
  assign running_out = mode_reg[`TMC_BIT_START];
  assign pulse_mode_out = eff_pwm;
  assign triggered_wave_out = wave_mode;
  assign pairing_out = {pair_d, pair_c};
  assign main_counter_out = cnt_reg;

  ////////////////////////////////////////////////////////////////
  // Count source and general registers
  tmc_src_sel u_src (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(mode_reg[`TMC_BIT_START]),
    .src_in(ctrl_reg[`TMC_SRC_LSB +: 3]),
    .fast_clk_in(fast_onchip_osc_clock_in),
    .ext_clk_in(external_count_clock_in),
    .tick_out(tick)
  );

  assign gen_wr = wr_in & (addr_in[9:3] == GEN_BASE[9:3]) & addr_in[0];
  assign gen_idx = addr_in[2:1];

  tmc_gen_mem #(
    .WIDTH(CNT_W)
  ) u_gen (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(gen_wr),
    .wr_idx_in(gen_idx),
    .wr_data_in({wdata_in, lvl_hold(gen_idx)}),
    .rd_idx_in(gen_idx),
    .rd_data_out(gen_rd),
    .all_out(gen_all)
  );

  ////////////////////////////////////////////////////////////////
  // Channel events
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : ch
      assign cap_hit[g] = capture_sel_in[g] & ~eff_pwm[g] & ~wave_mode &
                          edge_hit(edge_reg[2*g +: 2], pin_in[g], pin_d_reg[g]);
      assign cmp_hit[g] = ~(capture_sel_in[g] & ~eff_pwm[g] & ~wave_mode) & tick &
                          (cnt_reg == gen_word(gen_all, g));
    end
  endgenerate
  assign evt = cap_hit | cmp_hit;
  assign ovf_evt = tick & (cnt_reg == {CNT_W{1'b1}}) & ~(clear_a & cmp_hit[0]);

  // Counter next value
  always @*
  begin
    cnt_next = cnt_reg;
    if (tick)
    begin
      if (clear_a & cmp_hit[0])
        cnt_next = {CNT_W{1'b0}};
      else
        cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Flag update: a new event beats a clearing write in the same cycle
  always @*
  begin
    flag_next = flag_reg;
    if (wr_in && addr_in == `TMC_ADR_FLAGS)
      flag_next = flag_reg & ~(seen_reg & ~{wdata_in[`TMC_BIT_OVF], wdata_in[3:0]});
    flag_next = flag_next | {ovf_evt, evt};
  end

  ////////////////////////////////////////////////////////////////
  // Register writes and state
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mode_reg <= `TMC_RST_MODE;
      ctrl_reg <= `TMC_RST_CTRL1;
      edge_reg <= `TMC_RST_EDGE;
      flag_reg <= 5'h00;
      seen_reg <= 5'h00;
      cnt_reg <= {CNT_W{1'b0}};
      pin_d_reg <= 4'h0;
      lvl_reg <= 4'h0;
      for (j = 0; j < 4; j = j + 1)
        lo_hold_reg[j] <= 8'h00;
    end
    else
    begin
      flag_reg <= flag_next;
      cnt_reg <= cnt_next;
      pin_d_reg <= pin_in;
      // Remember flags read as 1; only those may be cleared later
      if (rd_in && addr_in == `TMC_ADR_FLAGS)
        seen_reg <= flag_reg;
      else if (wr_in && addr_in == `TMC_ADR_FLAGS)
        seen_reg <= 5'h00;
      if (wr_in)
      begin
        case (addr_in)
          `TMC_ADR_MODE: mode_reg <= wdata_in & `TMC_MODE_WMASK;
          `TMC_ADR_CTRL1: ctrl_reg <= wdata_in;
          `TMC_ADR_EDGE: edge_reg <= wdata_in;
          `TMC_ADR_CNT_LO: cnt_reg <= {cnt_reg[CNT_W-1:8], wdata_in};
          `TMC_ADR_CNT_HI: cnt_reg <= {wdata_in, cnt_reg[7:0]};
          default:
          begin
            if (addr_in[9:3] == GEN_BASE[9:3] && !addr_in[0])
              lo_hold_reg[gen_idx] <= wdata_in;
          end
        endcase
      end
      // Output level toggles on compare events; level bits ignored in capture
      for (j = 0; j < 4; j = j + 1)
      begin
        if (capture_sel_in[j] & ~eff_pwm[j] & ~wave_mode)
          lvl_reg[j] <= 1'b0;
        else if (cmp_hit[j])
          lvl_reg[j] <= ~lvl_reg[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drive: level select sets polarity, capture channels release the pin
  always @*
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      pin_oe_out[k] = ~(capture_sel_in[k] & ~eff_pwm[k] & ~wave_mode);
      pin_out[k] = pin_oe_out[k] & (lvl_reg[k] ^ ctrl_reg[k]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read path: data valid only the cycle after the strobe
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rd_mux_reg <= 8'h00;
      rd_gen_reg <= 1'b0;
      rd_lo_reg <= 1'b0;
    end
    else
    begin
      rd_gen_reg <= rd_in & (addr_in[9:3] == GEN_BASE[9:3]);
      rd_lo_reg <= ~addr_in[0];
      rd_mux_reg <= 8'h00;
      if (rd_in)
      begin
        case (addr_in)
          `TMC_ADR_MODE: rd_mux_reg <= mode_reg | `TMC_MODE_ONES;
          `TMC_ADR_CTRL1: rd_mux_reg <= ctrl_reg;
          `TMC_ADR_FLAGS: rd_mux_reg <= {flag_reg[4], 3'h7, flag_reg[3:0]};
          `TMC_ADR_EDGE: rd_mux_reg <= edge_reg;
          `TMC_ADR_CNT_LO: rd_mux_reg <= cnt_reg[7:0];
          `TMC_ADR_CNT_HI: rd_mux_reg <= cnt_reg[CNT_W-1:8];
          default: rd_mux_reg <= 8'h00;
        endcase
      end
    end
  end

  // Strobe-free cycles read zero
  always @*
  begin
    if (rd_gen_reg)
      rdata_out = rd_lo_reg ? gen_rd[7:0] : gen_rd[CNT_W-1:8];
    else
      rdata_out = rd_mux_reg;
  end
endmodule
`default_nettype wire

// *** tmc_map.vh ***
// Register map, field positions, reset values and count source codes for the timer
// mode/control/status block. Included by the core, the count source selector and the bench.
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
`define TMC_ADDR_W 10
`define TMC_ADR_MODE 10'h120
`define TMC_ADR_CTRL1 10'h121
`define TMC_ADR_FLAGS 10'h123
`define TMC_ADR_EDGE 10'h124
`define TMC_ADR_CNT_LO 10'h126
`define TMC_ADR_CNT_HI 10'h127
`define TMC_ADR_GEN_BASE 10'h128
`define TMC_RST_MODE 8'h48
`define TMC_RST_CTRL1 8'h00
`define TMC_RST_FLAGS 8'h70
`define TMC_RST_EDGE 8'h00
`define TMC_MODE_WMASK 8'hbf
`define TMC_MODE_ONES 8'h40
`define TMC_FLAGS_ONES 8'h70
`define TMC_BIT_PIN_B_PULSE_SELECT 0
`define TMC_BIT_PIN_C_PULSE_SELECT 1
`define TMC_BIT_PIN_D_PULSE_SELECT 2
`define TMC_BIT_WAVE 3
`define TMC_BIT_BFC 4
`define TMC_BIT_BFD 5
`define TMC_BIT_START 7
`define TMC_BIT_COUNTER_CLEAR_SELECT 7
`define TMC_BIT_OVF 7
`define TMC_SRC_LSB 4
`define TMC_SRC_F1 3'h0
`define TMC_SRC_F2 3'h1
`define TMC_SRC_F4 3'h2
`define TMC_SRC_F8 3'h3
`define TMC_SRC_F32 3'h4
`define TMC_SRC_EXT 3'h5
`define TMC_SRC_FAST 3'h6
`define TMC_EDGE_RISE 2'h0
`define TMC_EDGE_FALL 2'h1
`endif

// *** tmc_gen_mem.v ***
// Four 16-bit general registers A..D held in a small memory.
// Assumes one write port and one registered read port, both on clk_in.
`timescale 1ns/100ps
`default_nettype none
module tmc_gen_mem #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire reset_in,
  input wire wr_en_in,
  input wire [1:0] wr_idx_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire [1:0] rd_idx_in,
  output reg [WIDTH-1:0] rd_data_out,
  output wire [4*WIDTH-1:0] all_out
);
  reg [WIDTH-1:0] mem_reg [0:3];
  integer i;
  ////////////////////////////////////////////////////////////////
  // Write port plus registered read
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (i = 0; i < 4; i = i + 1)
        mem_reg[i] <= {WIDTH{1'b1}};
      rd_data_out <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_en_in)
        mem_reg[wr_idx_in] <= wr_data_in;
      rd_data_out <= mem_reg[rd_idx_in];
    end
  end
  // Flat view for compare logic
  assign all_out = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
endmodule
`default_nettype wire

// *** tmc_src_sel.v ***
// Count source selector: prescaler taps, fast clock and external edge.
// Assumes the fast oscillator and external clock are already synchronous levels.
`include "tmc_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tmc_src_sel (
  input wire clk_in,
  input wire reset_in,
  input wire run_in,
  input wire [2:0] src_in,
  input wire fast_clk_in,
  input wire ext_clk_in,
  output reg tick_out
);
  reg [4:0] pre_reg;
  reg ext_d_reg;
  reg fast_d_reg;
  ////////////////////////////////////////////////////////////////
  // Prescaler and edge history; prescaler free runs so taps stay aligned
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pre_reg <= 5'h00;
      ext_d_reg <= 1'b0;
      fast_d_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_reg + 5'h01;
      ext_d_reg <= ext_clk_in;
      fast_d_reg <= fast_clk_in;
    end
  end
  // Tick decode per source code
  always @*
  begin
    case (src_in)
      `TMC_SRC_F1: tick_out = run_in;
      `TMC_SRC_F2: tick_out = run_in & (pre_reg[0] == 1'b1);
      `TMC_SRC_F4: tick_out = run_in & (pre_reg[1:0] == 2'h3);
      `TMC_SRC_F8: tick_out = run_in & (pre_reg[2:0] == 3'h7);
      `TMC_SRC_F32: tick_out = run_in & (pre_reg == 5'h1f);
      `TMC_SRC_EXT: tick_out = run_in & ext_clk_in & ~ext_d_reg;
      `TMC_SRC_FAST: tick_out = run_in & fast_clk_in & ~fast_d_reg;
      default: tick_out = 1'b0; // Prohibited code never counts
    endcase
  end
endmodule
`default_nettype wire

// *** tmc_core_sva.sv ***
// Port checker for the timer mode/control/status block.
// Assumes binding onto tmc_core, one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module tmc_core_sva #(
  parameter CNT_W = 16
) (
  input wire clk_in,
  input wire reset_in,
  input wire [9:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire [3:0] capture_sel_in,
  input wire [3:0] pin_oe_out,
  input wire [CNT_W-1:0] main_counter_out,
  input wire [3:0] pulse_mode_out,
  input wire triggered_wave_out,
  input wire [1:0] pairing_out,
  input wire running_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  // Bus steps that open the mode and flag checks
  sequence s_mode_wr;
    wr_in && addr_in == 10'h120;
  endsequence
  sequence s_mode_rd;
    rd_in && addr_in == 10'h120;
  endsequence
  sequence s_flag_rd;
    rd_in && addr_in == 10'h123;
  endsequence
  property p_wave;
    s_mode_wr |=> triggered_wave_out == !$past(wdata_in[3]);
  endproperty
  property p_pulse;
    s_mode_wr |=> pulse_mode_out == ($past(wdata_in[3]) ? {$past(wdata_in[2:0]), 1'b0} : 4'h0);
  endproperty
  property p_pair;
    s_mode_wr |=> pairing_out == $past(wdata_in[5:4]);
  endproperty
  property p_run;
    s_mode_wr |=> running_out == $past(wdata_in[7]);
  endproperty
  property p_mode_one;
    s_mode_rd |=> rdata_out[6];
  endproperty
  property p_flag_ones;
    s_flag_rd |=> rdata_out[6:4] == 3'h7;
  endproperty
  // A stopped counter moves only by a register write
  property p_stop;
    !running_out && !wr_in |=> $stable(main_counter_out);
  endproperty
  property p_wrap;
    running_out && !wr_in && main_counter_out == 16'hffff |=> main_counter_out inside {16'hffff, 16'h0000};
  endproperty
  // Capture releases the pin only in timer mode on a non-PWM channel
  property p_cap;
    !triggered_wave_out |-> (pin_oe_out & capture_sel_in & ~pulse_mode_out) == 4'h0;
  endproperty
  a_wave: assert property (p_wave) else $error("wave mode output wrong");
  a_pulse: assert property (p_pulse) else $error("pulse select output wrong");
  a_pair: assert property (p_pair) else $error("pairing output wrong");
  a_run: assert property (p_run) else $error("running output wrong");
  a_mode_one: assert property (p_mode_one) else $error("mode bit 6 read as 0");
  a_flag_ones: assert property (p_flag_ones) else $error("flag bits 6 to 4 not ones");
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
  a_cap: assert property (p_cap) else $error("capture pin driven");
endmodule
bind tmc_core tmc_core_sva #(.CNT_W(CNT_W)) i_sva (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .capture_sel_in(capture_sel_in),
  .pin_oe_out(pin_oe_out), .main_counter_out(main_counter_out), .pulse_mode_out(pulse_mode_out),
  .triggered_wave_out(triggered_wave_out), .pairing_out(pairing_out), .running_out(running_out));
`default_nettype wire

// *** tmc_far_pins.sv ***
// Far side model: channel pins, external count clock, fast oscillator.
// Assumes the bench resolves each pin from the core's output enable.
`timescale 1ns/100ps
`default_nettype none
module tmc_far_pins (
  input wire logic clk_in,
  output logic [3:0] pin_drive_out,
  output logic ext_clk_out,
  output logic fast_clk_out
);
  // Oscillator runs free, 40 ns period, off the clock edges
  initial
  begin
    pin_drive_out = 4'h0;
    ext_clk_out = 1'b0;
    fast_clk_out = 1'b0;
    #3;
    forever #20 fast_clk_out = ~fast_clk_out;
  end
  // External clock idles low, one rising edge per pulse
  task ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_in) ext_clk_out <= 1'b1;
      @(posedge clk_in) ext_clk_out <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  // Rising pin edge, level then held
  task pin_rise(input int j);
    @(posedge clk_in) pin_drive_out[j] <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tmc_core_tb_top.sv ***
// Self-checking bench for the timer mode/control/status block.
// Assumes tmc_core, its checker and the far side model.
`include "tmc_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tmc_core_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [9:0] addr_in = 10'h000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] capture_sel_in = 4'h0;
  logic [7:0] v;
  logic [7:0] w;
  logic [7:0] src_exp [8] = '{8'd64, 8'd32, 8'd16, 8'd8, 8'd2, 8'd0, 8'd16, 8'd0};
  logic [7:0] modes [4] = '{8'h00, 8'h3f, 8'h07, 8'h2a};
  wire [7:0] rdata_out;
  wire [3:0] pin_out;
  wire [3:0] pin_oe_out;
  wire [3:0] pin_drv;
  wire [3:0] pin_w;
  wire [15:0] cnt;
  wire [3:0] pulse;
  wire [1:0] pair;
  wire wave;
  wire run;
  wire ext_clk;
  wire fast_clk;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  // Pin level from both parties
  assign pin_w = (pin_oe_out & pin_out) | (~pin_oe_out & pin_drv);
  tmc_core i_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .capture_sel_in(capture_sel_in), .pin_in(pin_w),
    .external_count_clock_in(ext_clk), .fast_onchip_osc_clock_in(fast_clk), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .main_counter_out(cnt), .pulse_mode_out(pulse), .triggered_wave_out(wave),
    .pairing_out(pair), .running_out(run));
  tmc_far_pins i_far (.clk_in(clk_in), .pin_drive_out(pin_drv), .ext_clk_out(ext_clk), .fast_clk_out(fast_clk));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge clk_in) wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_in) rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Stop, then set control and counter, as software must
  task setup(input logic [7:0] c1, input logic [15:0] c);
    wr(`TMC_ADR_MODE, 8'h08);
    wr(`TMC_ADR_CTRL1, c1);
    wr(`TMC_ADR_CNT_LO, c[7:0]);
    wr(`TMC_ADR_CNT_HI, c[15:8]);
    rd(`TMC_ADR_FLAGS, v);
    wr(`TMC_ADR_FLAGS, 8'h00);
  endtask
  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`TMC_ADR_MODE, v);
    chk("mode", v, 8'h48);
    rd(`TMC_ADR_CTRL1, v);
    chk("ctrl1", v, 8'h00);
    rd(`TMC_ADR_FLAGS, v);
    chk("flags", v, 8'h70);
    rd(10'h1f0, v);
    chk("unmapped", v, 8'h00);
    chk("wave", wave, 8'h00);
    chk("run", run, 8'h00);
    chk("pins", {pin_oe_out, pin_out}, 8'hf0);
    wr(`TMC_ADR_CTRL1, 8'h05);
    #1 chk("pin lvl", pin_out, 8'h05);
    $display("test reset done");
  endtask
  task t_mode;
    foreach (modes[i])
    begin
      wr(`TMC_ADR_MODE, modes[i]);
      rd(`TMC_ADR_MODE, v);
      chk("mode rd", v, modes[i] | 8'h40);
      chk("wave", wave, !modes[i][3]);
      chk("pulse", pulse, modes[i][3] ? {modes[i][2:0], 1'b0} : 4'h0);
      chk("pair", pair, modes[i][5:4]);
    end
    $display("test mode done");
  endtask
  task t_src;
    for (int s = 0; s < 8; s++)
    begin
      setup({1'b0, s[2:0], 4'h0}, 16'h0000);
      wr(`TMC_ADR_MODE, 8'h88);
      rd(`TMC_ADR_CNT_LO, v);
      repeat (62) @(posedge clk_in);
      rd(`TMC_ADR_CNT_LO, w);
      chk("ticks", w - v, src_exp[s]);
    end
    setup(8'h50, 16'h0000);
    wr(`TMC_ADR_MODE, 8'h88);
    i_far.ext_pulses(5);
    wr(`TMC_ADR_MODE, 8'h08);
    rd(`TMC_ADR_CNT_LO, v);
    chk("ext ticks", v, 8'd5);
    chk("ext cnt", cnt[7:0], 8'd5);
    $display("test source done");
  endtask
  task t_clear;
    setup(8'h80, 16'h0000);
    wr(`TMC_ADR_GEN_BASE, 8'h10);
    wr(`TMC_ADR_GEN_BASE + 10'h001, 8'h00);
    wr(`TMC_ADR_MODE, 8'h88);
    repeat (100) @(posedge clk_in);
    wr(`TMC_ADR_MODE, 8'h08);
    rd(`TMC_ADR_CNT_LO, v);
    chk("cleared", v <= 8'h10, 8'h01);
    rd(`TMC_ADR_FLAGS, v);
    chk("flag a", v[0], 8'h01);
    wr(`TMC_ADR_FLAGS, 8'hff);
    rd(`TMC_ADR_FLAGS, v);
    chk("flag a w1", v[0], 8'h01);
    wr(`TMC_ADR_FLAGS, 8'h00);
    rd(`TMC_ADR_FLAGS, v);
    chk("flags clr", v, 8'h70);
    wr(`TMC_ADR_MODE, 8'h88);
    repeat (40) @(posedge clk_in);
    wr(`TMC_ADR_MODE, 8'h08);
    wr(`TMC_ADR_FLAGS, 8'h00);
    rd(`TMC_ADR_FLAGS, v);
    chk("flag a late", v[0], 8'h01);
    $display("test clear done");
  endtask
  task t_ovf;
    setup(8'h00, 16'hfff0);
    wr(`TMC_ADR_MODE, 8'h88);
    repeat (40) @(posedge clk_in);
    wr(`TMC_ADR_MODE, 8'h08);
    rd(`TMC_ADR_FLAGS, v);
    chk("ovf", v[7], 8'h01);
    rd(`TMC_ADR_CNT_HI, v);
    chk("wrapped", v, 8'h00);
    $display("test overflow done");
  endtask
  task t_cap;
    setup(8'h8f, 16'h0000);
    capture_sel_in <= 4'h1;
    wr(`TMC_ADR_MODE, 8'h88);
    repeat (40) @(posedge clk_in);
    rd(`TMC_ADR_FLAGS, v);
    chk("no cap yet", v[0], 8'h00);
    i_far.pin_rise(0);
    repeat (4) @(posedge clk_in);
    wr(`TMC_ADR_MODE, 8'h08);
    rd(`TMC_ADR_FLAGS, v);
    chk("cap flag", v[0], 8'h01);
    rd(`TMC_ADR_CNT_LO, v);
    chk("free run", v > 8'h10, 8'h01);
    $display("test capture done");
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_mode();
    t_src();
    t_clear();
    t_ovf();
    t_cap();
    complete_run();
  end
endmodule
`default_nettype wire
